// [rtl/rtac_params.svh]
// register offsets, field positions, reset values and fixed constants
`ifndef RTAC_PARAMS_SVH
`define RTAC_PARAMS_SVH

`define RTAC_OFS_MASK      8'ha8
`define RTAC_OFS_ADDR      8'ha9
`define RTAC_OFS_VCALC     8'haa
`define RTAC_OFS_IGAIN     8'hab
`define RTAC_OFS_IOFS      8'hac
`define RTAC_OFS_AVSCAL    8'had
`define RTAC_OFS_ITH       8'hae
`define RTAC_OFS_APSCTRL   8'haf

`define RTAC_RST_MASK      16'hffff
`define RTAC_RST_ADDR      16'h0020
`define RTAC_RST_VCALC     16'h0080
`define RTAC_RST_IGAIN     16'h0000
`define RTAC_RST_IOFS      16'h0000
`define RTAC_RST_AVSCAL    16'h0000
`define RTAC_RST_ITH       16'h0000
`define RTAC_RST_APSCTRL   16'h0001

`define RTAC_BIT_OTP       15
`define RTAC_BIT_OVP       14
`define RTAC_BIT_UVP       13
`define RTAC_BIT_LIMW      12
`define RTAC_BIT_OCP       11
`define RTAC_BIT_SCP       10
`define RTAC_BIT_ADDRMODE  7

`define RTAC_VCALC_MASK    16'h3fff
`define RTAC_TCOEF_FIX1    16'h500a
`define RTAC_TCOEF_FIX3    16'h64b5
`define RTAC_IRES_BASE     6
`define RTAC_VREP_NUM      1024

`endif

// [rtl/rtac_pkg.sv]
// types shared by the alert and configuration block
package rtac_pkg;
    typedef enum logic [1:0] {
        RTAC_LVL_3V3  = 2'h0,
        RTAC_LVL_1V8  = 2'h1,
        RTAC_LVL_CFG  = 2'h2,
        RTAC_LVL_1V2  = 2'h3
    } rtac_level_type;

    typedef enum logic [1:0] {
        RTAC_ST_FULL = 2'h1,
        RTAC_ST_SHED = 2'h2
    } rtac_shed_type;
endpackage

// [rtl/rtac_telemetry_alert_config.sv]
// rail 1 telemetry trim, alert mask, bus address and phase shedding config
`timescale 1ns/1ps
`include "rtac_params.svh"

module rtac_telemetry_alert_config #(
    parameter int PHW  = 5,
    parameter int SENW = 12,
    parameter int TUNW = 10
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [7:0]        regAddr,
    input  wire logic [15:0]       regWdata,
    output logic [15:0]            regRdata,
    output logic                   regHit,
    input  wire logic [3:0]        addrStrap,
    input  wire logic [15:0]       faultPending,
    output logic                   fault_alert_out_n,
    output logic [6:0]             busAddress,
    output rtac_pkg::rtac_level_type avs_pin_level_select,
    output rtac_pkg::rtac_level_type mgmt_pin_level_select,
    input  wire logic [15:0]       tempCoefStored,
    output logic [15:0]            driverTempCoefR1,
    output logic [15:0]            driverTempCoefR2,
    input  wire logic [SENW-1:0]   senseVoltage,
    input  wire logic [7:0]        reference_step_size,
    output logic [23:0]            voutReport,
    output logic [2:0]             monitor_resistor_select,
    output logic                   monitorDisconnect,
    output logic                   mirror_ratio_select,
    input  wire logic [SENW-1:0]   currentSense,
    output logic [23:0]            ioutReport,
    input  wire logic              avsHighRes,
    output logic [23:0]            avsIoutReport,
    input  wire logic [TUNW-1:0]   balanceTune,
    input  wire logic [6:0]        imbalanceLower,
    output logic                   phaseAbnormal,
    input  wire logic [PHW-1:0]    activePhases,
    input  wire logic              reportTick,
    output logic [11:0]            shedLevel,
    output logic [11:0]            shedHysteresis,
    output logic                   auto_phase_drop
);
    logic [15:0] maskQ, addrQ, vcalcQ, igainQ, iofsQ, avsQ, ithQ, apsQ;
    logic [15:0] faultSync1Q, faultSync2Q;
    logic [3:0]  strapSync1Q, strapSync2Q;
    logic [3:0]  strapNibble;
    logic [15:0] addrRead;
    logic        scpEvent;
    logic [15:0] faultEff;
    logic        wrMask, wrAddr, wrVcalc, wrIgain, wrIofs, wrAvs, wrIth, wrAps;
    rtac_pkg::rtac_shed_type shedQ;
    logic [4:0]  belowCntQ;
    logic signed [31:0] vScaled, vOfs, iScaled, iOfs, aScaled, aOfs;
    logic [3:0]  ampTenths;

    // fault and strap inputs come from other domains
    always_ff @(posedge clk) begin
        faultSync1Q <= faultPending;
        faultSync2Q <= faultSync1Q;
        strapSync1Q <= addrStrap;
        strapSync2Q <= strapSync1Q;
    end

    assign wrMask  = regWrite && regAddr == `RTAC_OFS_MASK;
    assign wrAddr  = regWrite && regAddr == `RTAC_OFS_ADDR;
    assign wrVcalc = regWrite && regAddr == `RTAC_OFS_VCALC;
    assign wrIgain = regWrite && regAddr == `RTAC_OFS_IGAIN;
    assign wrIofs  = regWrite && regAddr == `RTAC_OFS_IOFS;
    assign wrAvs   = regWrite && regAddr == `RTAC_OFS_AVSCAL;
    assign wrIth   = regWrite && regAddr == `RTAC_OFS_ITH;
    assign wrAps   = regWrite && regAddr == `RTAC_OFS_APSCTRL;

    always_ff @(posedge clk) begin
        if (rst) begin
            maskQ <= `RTAC_RST_MASK;
        end else if (wrMask) begin
            maskQ <= regWdata;
        end
    end

    // strap mode keeps the low nibble untouched so reads show the strap instead
    always_ff @(posedge clk) begin
        if (rst) begin
            addrQ <= `RTAC_RST_ADDR;
        end else if (wrAddr) begin
            if (regWdata[`RTAC_BIT_ADDRMODE]) begin
                addrQ <= regWdata;
            end else begin
                addrQ <= {regWdata[15:4], addrQ[3:0]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vcalcQ <= `RTAC_RST_VCALC;
        end else if (wrVcalc) begin
            vcalcQ <= regWdata & `RTAC_VCALC_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            igainQ <= `RTAC_RST_IGAIN;
            iofsQ  <= `RTAC_RST_IOFS;
            avsQ   <= `RTAC_RST_AVSCAL;
            ithQ   <= `RTAC_RST_ITH;
            apsQ   <= `RTAC_RST_APSCTRL;
        end else begin
            if (wrIgain) begin
                igainQ <= regWdata;
            end
            if (wrIofs) begin
                iofsQ <= regWdata;
            end
            if (wrAvs) begin
                avsQ <= regWdata;
            end
            if (wrIth) begin
                ithQ <= regWdata;
            end
            if (wrAps) begin
                apsQ <= regWdata;
            end
        end
    end

    // address nibble source
    assign strapNibble = addrQ[`RTAC_BIT_ADDRMODE] ? addrQ[3:0] : strapSync2Q;
    assign addrRead    = {addrQ[15:4], strapNibble};

    always_ff @(posedge clk) begin
        if (rst) begin
            busAddress <= 7'h00;
        end else begin
            busAddress <= addrRead[6:0];
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        regHit   = 1'b1;
        regRdata = 16'h0000;
        unique case (regAddr)
            `RTAC_OFS_MASK:    regRdata = maskQ;
            `RTAC_OFS_ADDR:    regRdata = addrRead;
            `RTAC_OFS_VCALC:   regRdata = vcalcQ;
            `RTAC_OFS_IGAIN:   regRdata = igainQ;
            `RTAC_OFS_IOFS:    regRdata = iofsQ;
            `RTAC_OFS_AVSCAL:  regRdata = avsQ;
            `RTAC_OFS_ITH:     regRdata = ithQ;
            `RTAC_OFS_APSCTRL: regRdata = apsQ;
            default:           regHit = 1'b0;
        endcase
        if (!regRead) begin
            regRdata = 16'h0000;
        end
    end

    // short circuit is its own source, raised only by oc and uv together
    assign scpEvent = faultSync2Q[`RTAC_BIT_OCP] && faultSync2Q[`RTAC_BIT_UVP];

    always_comb begin
        faultEff = faultSync2Q & maskQ;
        faultEff[`RTAC_BIT_OTP] = faultSync2Q[`RTAC_BIT_OTP] && maskQ[`RTAC_BIT_OTP];
        faultEff[`RTAC_BIT_SCP] = scpEvent && maskQ[`RTAC_BIT_SCP];
        // a masked short keeps oc and uv silent while both are present
        if (scpEvent && !maskQ[`RTAC_BIT_SCP]) begin
            faultEff[`RTAC_BIT_OCP] = 1'b0;
            faultEff[`RTAC_BIT_UVP] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fault_alert_out_n <= 1'b1;
        end else begin
            fault_alert_out_n <= ~|faultEff;
        end
    end

    // interface levels and temperature coefficients
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_pin_level_select  <= rtac_pkg::RTAC_LVL_3V3;
            mgmt_pin_level_select <= rtac_pkg::RTAC_LVL_3V3;
            driverTempCoefR1      <= 16'h0000;
            driverTempCoefR2      <= 16'h0000;
        end else begin
            avs_pin_level_select  <= rtac_pkg::rtac_level_type'(addrQ[15:14]);
            mgmt_pin_level_select <= rtac_pkg::rtac_level_type'(addrQ[13:12]);
            unique case (addrQ[9:8])
                2'h1:    driverTempCoefR1 <= `RTAC_TCOEF_FIX1;
                2'h3:    driverTempCoefR1 <= `RTAC_TCOEF_FIX3;
                default: driverTempCoefR1 <= tempCoefStored;
            endcase
            unique case (addrQ[11:10])
                2'h1:    driverTempCoefR2 <= `RTAC_TCOEF_FIX1;
                2'h3:    driverTempCoefR2 <= `RTAC_TCOEF_FIX3;
                default: driverTempCoefR2 <= tempCoefStored;
            endcase
        end
    end

    // sense amp gain in tenths, divisor folds 1.6 and 10 into 16
    always_comb begin
        unique case (apsQ[11:10])
            2'h0: ampTenths = 4'd10;
            2'h1: ampTenths = 4'd5;
            2'h2: ampTenths = 4'd8;
            2'h3: ampTenths = 4'd4;
        endcase
    end

    // arithmetic in integers; fractional lsbs are truncated
    assign vScaled = ($signed({1'b0, senseVoltage}) * `RTAC_VREP_NUM
                     * $signed({1'b0, ampTenths}) / 16
                     * $signed({1'b0, vcalcQ[7:0]})) >>> 7;
    assign vOfs    = $signed(vcalcQ[13:8]) * $signed({1'b0, reference_step_size});

    assign iScaled = ($signed({1'b0, currentSense}) * $signed({1'b0, igainQ[9:0]})
                     <<< (`RTAC_IRES_BASE - igainQ[11:10])) >>> `RTAC_IRES_BASE;
    assign iOfs    = $signed(iofsQ[12:6]) * $signed({1'b0, activePhases})
                     + $signed({1'b0, iofsQ[5:0]});

    assign aScaled = $signed({1'b0, currentSense}) * $signed({1'b0, avsQ[10:0]});
    assign aOfs    = $signed(avsQ[15:11]) * (avsHighRes ? 32 : 16);

    always_ff @(posedge clk) begin
        if (rst) begin
            voutReport    <= 24'h000000;
            ioutReport    <= 24'h000000;
            avsIoutReport <= 24'h000000;
        end else begin
            voutReport    <= 24'(vScaled + vOfs);
            ioutReport    <= 24'(iScaled + iOfs);
            avsIoutReport <= 24'(aScaled + aOfs); // avs lsb is 10 mA units
        end
    end

    // monitor front end configuration
    always_ff @(posedge clk) begin
        if (rst) begin
            monitor_resistor_select <= 3'h0;
            monitorDisconnect       <= 1'b0;
            mirror_ratio_select     <= 1'b0;
            phaseAbnormal           <= 1'b0;
        end else begin
            monitor_resistor_select <= igainQ[15:13];
            monitorDisconnect       <= igainQ[15];
            mirror_ratio_select     <= igainQ[12];
            phaseAbnormal <= {iofsQ[15:13], imbalanceLower} < 10'(balanceTune);
        end
    end

    // shedding thresholds
    always_ff @(posedge clk) begin
        if (rst) begin
            shedLevel      <= 12'h000;
            shedHysteresis <= 12'h000;
        end else begin
            shedLevel      <= 12'(activePhases * ithQ[9:4] + ithQ[3:0]);
            shedHysteresis <= 12'(activePhases * ithQ[15:14] + ithQ[13:10]);
        end
    end

    // entry needs a full run of report cycles below the level; any rise restarts
    always_ff @(posedge clk) begin
        if (rst) begin
            shedQ     <= rtac_pkg::RTAC_ST_FULL;
            belowCntQ <= 5'h00;
        end else if (reportTick) begin
            unique case (shedQ)
                rtac_pkg::RTAC_ST_FULL: begin
                    if (ioutReport >= 24'(shedLevel)) begin
                        belowCntQ <= 5'h00;
                    end else if (belowCntQ + 5'h01 >= apsQ[4:0]) begin
                        shedQ     <= rtac_pkg::RTAC_ST_SHED;
                        belowCntQ <= 5'h00;
                    end else begin
                        belowCntQ <= belowCntQ + 5'h01;
                    end
                end
                rtac_pkg::RTAC_ST_SHED: begin
                    if (ioutReport >= 24'(shedLevel + shedHysteresis)) begin
                        shedQ <= rtac_pkg::RTAC_ST_FULL;
                    end
                end
                default: shedQ <= rtac_pkg::RTAC_ST_FULL;
            endcase
        end
    end

    assign auto_phase_drop = shedQ == rtac_pkg::RTAC_ST_SHED;
endmodule

// [sim/rtac_host_model.sv]
// host-side register access model for the rail 1 config block
`timescale 1ns/1ps
module rtac_host_model (
    input  wire logic        clk,
    output logic             regWrite,
    output logic             regRead,
    output logic [7:0]       regAddr,
    output logic [15:0]      regWdata,
    input  wire logic [15:0] regRdata
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 16'h0000;
    end

    // write taken at the second edge; data inverted after so stale values never match
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        d = regRdata;
        regRead <= 1'b0;
    endtask
endmodule

// [sim/rtac_config_properties.sv]
// port-level checks for the rail 1 alert and config block
`timescale 1ns/1ps
module rtac_config_properties (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    regWrite,
    input wire logic                    regRead,
    input wire logic [7:0]              regAddr,
    input wire logic [15:0]             regWdata,
    input wire logic [15:0]             regRdata,
    input wire logic [15:0]             faultPending,
    input wire logic                    fault_alert_out_n,
    input wire logic [6:0]              busAddress,
    input wire rtac_pkg::rtac_level_type avs_pin_level_select,
    input wire rtac_pkg::rtac_level_type mgmt_pin_level_select,
    input wire logic [15:0]             driverTempCoefR1,
    input wire logic [2:0]              monitor_resistor_select,
    input wire logic                    monitorDisconnect,
    input wire logic                    mirror_ratio_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wrId;
    assign wrId = regWrite && regAddr == 8'ha9;

    a_trim_top_zero: assert property (regRead && regAddr == 8'haa |-> regRdata[15:14] == 2'h0)
        else $error("trim top bits not zero");
    a_level_follows: assert property (wrId |-> ##2 avs_pin_level_select == $past(regWdata[15:14], 2)
        && mgmt_pin_level_select == $past(regWdata[13:12], 2)) else $error("level select wrong");
    a_coef_fixed: assert property (wrId && regWdata[8] |-> ##2 driverTempCoefR1 ==
        ($past(regWdata[9], 2) ? 16'h64b5 : 16'h500a)) else $error("fixed coef wrong");
    a_addr_full: assert property (wrId && regWdata[7] |-> ##2 busAddress == $past(regWdata[6:0], 2))
        else $error("register address wrong");
    a_addr_upper: assert property (wrId |-> ##2 busAddress[6:4] == $past(regWdata[6:4], 2))
        else $error("upper address wrong");
    a_strap_readback: assert property (regRead && regAddr == 8'ha9 && !regRdata[7]
        |-> regRdata[3:0] == busAddress[3:0]) else $error("strap nibble readback wrong");
    a_monitor_fields: assert property (regWrite && regAddr == 8'hab |-> ##2
        {monitor_resistor_select, mirror_ratio_select, monitorDisconnect}
        == {$past(regWdata[15:12], 2), $past(regWdata[15], 2)}) else $error("monitor fields wrong");
    a_mask_clear_quiet: assert property (regWrite && regAddr == 8'ha8 && regWdata == 16'h0
        |-> ##2 fault_alert_out_n) else $error("alert with all masked");
    a_alert_cause: assert property (!fault_alert_out_n |-> $past(faultPending, 3) != 16'h0)
        else $error("alert without fault");

    c_alert_low: cover property (!fault_alert_out_n);
    c_strap_mode: cover property (wrId && !regWdata[7]);
    c_mask_clear: cover property (regWrite && regAddr == 8'ha8 && regWdata == 16'h0);
endmodule

bind rtac_telemetry_alert_config rtac_config_properties u_props (.clk, .rst, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .faultPending, .fault_alert_out_n, .busAddress,
    .avs_pin_level_select, .mgmt_pin_level_select, .driverTempCoefR1,
    .monitor_resistor_select, .monitorDisconnect, .mirror_ratio_select);

// [sim/rtac_telemetry_alert_config_tb_top.sv]
// self-checking bench for the rail 1 alert and config block
`timescale 1ns/1ps
module rtac_telemetry_alert_config_tb_top;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     regWrite, regRead, regHit, fault_alert_out_n, monitorDisconnect;
    logic [7:0]               regAddr;
    logic [15:0]              regWdata, regRdata, driverTempCoefR1, driverTempCoefR2;
    logic [3:0]               addrStrap = 4'h5;
    logic [15:0]              faultPending = 16'h0000;
    logic [15:0]              tempCoefStored = 16'h1234;
    logic [6:0]               busAddress;
    rtac_pkg::rtac_level_type avs_pin_level_select, mgmt_pin_level_select;
    logic [11:0]              senseVoltage = 12'h100;
    logic [11:0]              currentSense = 12'h000;
    logic [7:0]               reference_step_size = 8'h01;
    logic [23:0]              voutReport, ioutReport, avsIoutReport;
    logic [2:0]               monitor_resistor_select;
    logic                     mirror_ratio_select, phaseAbnormal, auto_phase_drop;
    logic                     avsHighRes = 1'b0;
    logic                     reportTick = 1'b0;
    logic [9:0]               balanceTune = 10'h000;
    logic [6:0]               imbalanceLower = 7'h00;
    logic [4:0]               activePhases = 5'h10;
    logic [11:0]              shedLevel, shedHysteresis;
    int                       n_mismatch = 0;
    int                       cmp_count = 0;
    logic [15:0]              rstVal [8] = '{16'hffff, 16'h0025, 16'h0080, 16'h0, 16'h0, 16'h0,
                                             16'h0, 16'h0001};

    always #20 clk = ~clk;

    rtac_host_model host (.clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);

    rtac_telemetry_alert_config dut (.clk, .rst, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .regHit, .addrStrap, .faultPending, .fault_alert_out_n, .busAddress,
        .avs_pin_level_select, .mgmt_pin_level_select, .tempCoefStored, .driverTempCoefR1,
        .driverTempCoefR2, .senseVoltage, .reference_step_size, .voutReport,
        .monitor_resistor_select, .monitorDisconnect, .mirror_ratio_select, .currentSense,
        .ioutReport, .avsHighRes, .avsIoutReport, .balanceTune, .imbalanceLower, .phaseAbnormal,
        .activePhases, .reportTick, .shedLevel, .shedHysteresis, .auto_phase_drop);

    task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // derived outputs land one cycle after the register, so wait two edges
    task automatic wrs(input logic [7:0] a, input logic [15:0] d);
        host.wr(a, d);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_regs();
        logic [15:0] rv;
        logic [15:0] ex;
        for (int i = 0; i < 8; i++) begin
            host.rd(8'ha8 + 8'(i), rv);
            chk("reset value", 24'(rstVal[i]), 24'(rv));
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 9; i++) begin
                ex = (i == 8) ? 16'h0 : (p == 0) ? 16'hffff : 16'h0;
                if (i == 2)
                    ex = ex & 16'h3fff;
                if (i == 1 && p == 1)
                    ex[3:0] = addrStrap;
                host.wr(8'ha8 + 8'(i) - ((i == 8) ? 8'h9 : 8'h0), (p == 0) ? 16'hffff : 16'h0);
                host.rd(8'ha8 + 8'(i) - ((i == 8) ? 8'h9 : 8'h0), rv);
                chk("readback", 24'(ex), 24'(rv));
                chk("register hit", 24'(i != 8), 24'(regHit));
            end
        end
    endtask

    task automatic t_addr();
        logic [15:0] rv;
        wrs(8'ha9, 16'h00ea);
        chk("register address", 24'(7'h6a), 24'(busAddress));
        @(posedge clk) addrStrap <= 4'ha;
        wrs(8'ha9, 16'h0053);
        chk("strap address", 24'(7'h5a), 24'(busAddress));
        host.rd(8'ha9, rv);
        chk("strap readback", 24'(16'h005a), 24'(rv));
    endtask

    task automatic t_levels();
        for (int c = 0; c < 4; c++) begin
            wrs(8'ha9, {{4{2'(c)}}, 8'h80});
            chk("level select", 24'({2'(c), 2'(c)}),
                24'({avs_pin_level_select, mgmt_pin_level_select}));
            chk("coef r1", 24'(c[0] ? (c[1] ? 16'h64b5 : 16'h500a) : tempCoefStored),
                24'(driverTempCoefR1));
            chk("coef r2", 24'(c[0] ? (c[1] ? 16'h64b5 : 16'h500a) : tempCoefStored),
                24'(driverTempCoefR2));
        end
    endtask

    task automatic t_monitor();
        for (int c = 0; c < 8; c++) begin
            wrs(8'hab, {3'(c), c[0], 12'h0});
            chk("monitor fields", 24'({3'(c), c[2], c[0]}),
                24'({monitor_resistor_select, monitorDisconnect, mirror_ratio_select}));
        end
    endtask

    task automatic alert_case(input logic [15:0] m, input logic [15:0] f, input logic ex);
        wrs(8'ha8, m);
        @(posedge clk) faultPending <= f;
        repeat (4) @(posedge clk);
        #1;
        chk("alert", 24'(ex), 24'(fault_alert_out_n));
    endtask

    task automatic t_alert();
        for (int i = 0; i < 16; i++) begin
            if (i != 10) begin
                alert_case(16'hffff, 16'(1 << i), 1'b0);
                alert_case(~16'(1 << i), 16'(1 << i), 1'b1);
            end
        end
        alert_case(16'hfbff, 16'h2800, 1'b1);
        alert_case(16'hffff, 16'h2800, 1'b0);
        alert_case(16'h0000, 16'hffff, 1'b1);
        alert_case(16'hffff, 16'h0000, 1'b1);
    endtask

    task automatic t_shed();
        wrs(8'hae, 16'hffff);
        chk("shed level", 24'(12'h3ff), 24'(shedLevel));
        chk("shed hysteresis", 24'(12'h03f), 24'(shedHysteresis));
        @(posedge clk) activePhases <= 5'h02;
        repeat (2) @(posedge clk);
        #1;
        chk("shed level two", 24'(12'h08d), 24'(shedLevel));
        chk("shed hysteresis two", 24'(12'h015), 24'(shedHysteresis));
        wrs(8'haf, 16'h0000);
        chk("full phase", 24'(1'b0), 24'(auto_phase_drop));
        @(posedge clk) reportTick <= 1'b1;
        @(posedge clk) reportTick <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("shed entry", 24'(1'b1), 24'(auto_phase_drop));
        wrs(8'hac, 16'h2000);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) balanceTune <= 10'h081 - 10'(k);
            repeat (3) @(posedge clk);
            #1;
            chk("phase abnormal", 24'(k == 0), 24'(phaseAbnormal));
        end
    endtask

    // report arithmetic with two phases active and unit reference step
    task automatic t_reports();
        @(posedge clk) currentSense <= 12'h010;
        wrs(8'haf, 16'h0000);
        wrs(8'haa, 16'h3f80);
        chk("vout report", 24'h027fff, voutReport);
        wrs(8'haf, 16'h0400);
        chk("vout report half gain", 24'h013fff, voutReport);
        wrs(8'hab, 16'h0402);
        wrs(8'hac, 16'h1fc5);
        chk("iout report", 24'h000013, ioutReport);
        wrs(8'had, 16'hf803);
        chk("avs report", 24'h000020, avsIoutReport);
        @(posedge clk) avsHighRes <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("avs report high res", 24'h000010, avsIoutReport);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_addr();
        t_levels();
        t_monitor();
        t_alert();
        t_shed();
        t_reports();
        end_of_test();
    end

    // whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
